// [hdl/cto_pkg.sv]
// constants shared by the transfer and test executor
package cto_pkg;
  localparam int DW = 32;
  localparam int AW = 6;
  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] A_CMD   = 6'h00;
  localparam logic [AW-1:0] A_STAT  = 6'h04;
  localparam logic [AW-1:0] A_D     = 6'h08;
  localparam logic [AW-1:0] A_E     = 6'h0C;
  localparam logic [AW-1:0] A_X     = 6'h10;
  localparam logic [AW-1:0] A_MLO   = 6'h14;
  localparam logic [AW-1:0] A_MHI   = 6'h18;
  localparam logic [AW-1:0] A_FLG   = 6'h1C;
  localparam logic [AW-1:0] A_BANK  = 6'h20;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int F_C  = 0;
  localparam int F_V  = 1;
  localparam int F_Z  = 2;
  localparam int F_N  = 3;
  localparam int F_EV = 4;
  localparam int F_MV = 5;
  localparam int F_SM = 6;
  localparam int S_BUSY = 0;
  localparam int S_BAD  = 1;
  localparam int K_EK   = 0;
  localparam int K_SK   = 4;
  // ---------------------------------------------------------------
  // opcodes and cycle counts
  // ---------------------------------------------------------------
  localparam logic [15:0] OP_PAIR  = 16'h27B1;
  localparam logic [15:0] OP_HIGH  = 16'h27B2;
  localparam logic [15:0] OP_SPLIT = 16'h27B3;
  localparam logic [15:0] OP_RND   = 16'h27B4;
  localparam logic [15:0] OP_TRN   = 16'h27B5;
  localparam logic [15:0] OP_EKB   = 16'h27BB;
  localparam logic [15:0] OP_SKB   = 16'h37AF;
  localparam logic [15:0] OP_TSA   = 16'h3706;
  localparam logic [15:0] OP_TSB   = 16'h3716;
  localparam logic [15:0] OP_TSD   = 16'h27F6;
  localparam logic [15:0] OP_TSE   = 16'h2776;
  localparam logic [2:0]  CYC_2    = 3'h2;
  localparam logic [2:0]  CYC_4    = 3'h4;
  localparam logic [2:0]  CYC_6    = 3'h6;
  // ---------------------------------------------------------------
  // values
  // ---------------------------------------------------------------
  localparam logic [35:0] RND_ADD  = 36'h0_0000_8000;
  localparam logic [15:0] SAT_POS  = 16'h7FFF;
  localparam logic [15:0] SAT_NEG  = 16'h8000;
  localparam logic [15:0] W_ZERO   = 16'h0000;
  localparam logic [7:0]  B_ZERO   = 8'h00;
  localparam logic [3:0]  N_ZERO   = 4'h0;
  typedef enum logic {ST_IDLE, ST_EXEC} cto_state_type;
endpackage

// [hdl/cto_core.sv]
// executor for accumulator transfer and test operations, wishbone slave
//--------------------------------------------------------------------
//--------------------------------------------------------------------
//
// Added by the designer: the Wishbone register port and the placing of the registers.
module cto_core (
  input  wire logic                   CLK,
  input  wire logic                   RST,
  input  wire logic                   WB_CYC,
  input  wire logic                   WB_STB,
  input  wire logic                   WB_WE,
  input  wire logic [cto_pkg::AW-1:0] WB_ADR,
  input  wire logic [3:0]             WB_SEL,
  input  wire logic [cto_pkg::DW-1:0] WB_DAT_WR,
  output logic      [cto_pkg::DW-1:0] WB_DAT_RD,
  output logic                        WB_ACK,
  output logic      [3:0]             EXT_BANK
);
  import cto_pkg::*;

  typedef struct packed {
    cto_state_type st;
    logic [2:0]    cnt;
    logic [15:0]   op;
    logic [7:0]    a;
    logic [7:0]    b;
    logic [15:0]   e;
    logic [15:0]   x;
    logic [35:0]   am;
    logic          fc, fv, fz, fn, fev, fmv, sm, bad;
    logic [3:0]    ek;
    logic [3:0]    sk;
    logic          ack;
    logic [31:0]   rd;
  } cto_regs_type;

  cto_regs_type r_ff, nxt_r;

  //------------------------------------------------------------------
  // helpers
  //------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [31:0] v;
    v = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        v[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return v;
  endfunction

  logic        req;
  logic        fin;
  logic [15:0] d_w;
  logic [35:0] tmp;
  logic        r_ev, r_mv, sat_r, sat_t;
  logic [15:0] sat_v, e_r, e_t;
  logic [31:0] wv;
  logic [2:0]  cyc_n;
  logic        known;

  assign req   = WB_CYC & WB_STB & ~r_ff.ack;
  assign fin   = (r_ff.st == ST_EXEC) && (r_ff.cnt == 3'h0);
  assign d_w   = {r_ff.a, r_ff.b};
  // rounding adds half an lsb of the upper word
  assign tmp   = r_ff.am + RND_ADD;
  assign r_ev  = ~((&tmp[35:31]) | ~(|tmp[35:31]));
  assign r_mv  = ~r_ff.am[35] & tmp[35];
  assign sat_v = r_ff.am[35] ? SAT_NEG : SAT_POS;
  assign sat_r = r_ff.sm & (r_ev | r_mv);
  assign sat_t = r_ff.sm & (r_ff.fev | r_ff.fmv);
  assign e_r   = sat_r ? sat_v : tmp[31:16];
  assign e_t   = sat_t ? sat_v : r_ff.am[31:16];

  always_comb begin
    cyc_n = CYC_2;
    known = 1'b1;
    case (WB_DAT_WR[15:0])
      OP_PAIR, OP_HIGH: cyc_n = CYC_4;
      OP_SPLIT, OP_RND: cyc_n = CYC_6;
      OP_TRN, OP_EKB, OP_SKB, OP_TSA, OP_TSB, OP_TSD,
      OP_TSE:           cyc_n = CYC_2;
      default:          known = 1'b0;
    endcase
  end

  //------------------------------------------------------------------
  // next state
  //------------------------------------------------------------------
  always_comb begin
    nxt_r     = r_ff;
    wv        = 32'h0000_0000;
    nxt_r.ack = req;
    // software writes to operands land only while idle
    if (req && WB_WE && r_ff.st == ST_IDLE) begin
      case (WB_ADR)
        A_CMD: begin
          if (known) begin
            nxt_r.st  = ST_EXEC;
            nxt_r.op  = WB_DAT_WR[15:0];
            nxt_r.cnt = cyc_n - 3'h1;
          end
          nxt_r.bad = ~known;
        end
        A_D: begin
          wv = merge({16'h0000, d_w}, WB_DAT_WR, WB_SEL);
          {nxt_r.a, nxt_r.b} = wv[15:0];
        end
        A_E: begin
          wv = merge({16'h0000, r_ff.e}, WB_DAT_WR, WB_SEL);
          nxt_r.e = wv[15:0];
        end
        A_X: begin
          wv = merge({16'h0000, r_ff.x}, WB_DAT_WR, WB_SEL);
          nxt_r.x = wv[15:0];
        end
        A_MLO: nxt_r.am[31:0] = merge(r_ff.am[31:0], WB_DAT_WR, WB_SEL);
        A_MHI: if (WB_SEL[0]) nxt_r.am[35:32] = WB_DAT_WR[3:0];
        A_FLG: begin
          if (WB_SEL[0]) begin
            nxt_r.fc  = WB_DAT_WR[F_C];
            nxt_r.fv  = WB_DAT_WR[F_V];
            nxt_r.fz  = WB_DAT_WR[F_Z];
            nxt_r.fn  = WB_DAT_WR[F_N];
            nxt_r.fev = WB_DAT_WR[F_EV];
            nxt_r.fmv = WB_DAT_WR[F_MV];
            nxt_r.sm  = WB_DAT_WR[F_SM];
          end
        end
        A_BANK: begin
          if (WB_SEL[0]) begin
            nxt_r.ek = WB_DAT_WR[K_EK +: 4];
            nxt_r.sk = WB_DAT_WR[K_SK +: 4];
          end
        end
        default: ;
      endcase
    end

    if (r_ff.st == ST_EXEC) begin
      nxt_r.cnt = r_ff.cnt - 3'h1;
      if (fin) begin
        nxt_r.st = ST_IDLE;
        case (r_ff.op)
          OP_PAIR: begin
            nxt_r.am  = {{4{r_ff.e[15]}}, r_ff.e, d_w};
            nxt_r.fev = 1'b0;
            nxt_r.fmv = 1'b0;
          end
          OP_HIGH: begin
            nxt_r.am  = {{4{r_ff.e[15]}}, r_ff.e, W_ZERO};
            nxt_r.fev = 1'b0;
            nxt_r.fmv = 1'b0;
          end
          OP_EKB: nxt_r.b = {N_ZERO, r_ff.ek};
          OP_SKB: nxt_r.b = {N_ZERO, r_ff.sk};
          OP_RND: begin
            nxt_r.e   = e_r;
            nxt_r.fev = r_ev;
            nxt_r.fmv = r_mv;
            nxt_r.fn  = e_r[15];
            nxt_r.fz  = (e_r == W_ZERO);
          end
          OP_TRN: begin
            nxt_r.e  = e_t;
            nxt_r.fn = e_t[15];
            nxt_r.fz = (e_t == W_ZERO);
          end
          OP_SPLIT: begin
            nxt_r.x = {{12{r_ff.am[35]}}, r_ff.am[35:32]};
            nxt_r.e = r_ff.am[31:16];
            {nxt_r.a, nxt_r.b} = r_ff.am[15:0];
          end
          OP_TSA, OP_TSB: begin
            nxt_r.fn = (r_ff.op == OP_TSA) ? r_ff.a[7] : r_ff.b[7];
            nxt_r.fz = (r_ff.op == OP_TSA) ? (r_ff.a == B_ZERO)
                                           : (r_ff.b == B_ZERO);
            nxt_r.fv = 1'b0;
            nxt_r.fc = 1'b0;
          end
          OP_TSD, OP_TSE: begin
            nxt_r.fn = (r_ff.op == OP_TSD) ? d_w[15] : r_ff.e[15];
            nxt_r.fz = (r_ff.op == OP_TSD) ? (d_w == W_ZERO)
                                           : (r_ff.e == W_ZERO);
            nxt_r.fv = 1'b0;
            nxt_r.fc = 1'b0;
          end
          default: ;
        endcase
      end
    end

    // read data reflects state at the request cycle
    nxt_r.rd = 32'h0000_0000;
    if (req && !WB_WE) begin
      case (WB_ADR)
        A_CMD:  nxt_r.rd[15:0] = r_ff.op;
        A_STAT: begin
          nxt_r.rd[S_BUSY] = (r_ff.st == ST_EXEC);
          nxt_r.rd[S_BAD]  = r_ff.bad;
        end
        A_D:    nxt_r.rd[15:0] = d_w;
        A_E:    nxt_r.rd[15:0] = r_ff.e;
        A_X:    nxt_r.rd[15:0] = r_ff.x;
        A_MLO:  nxt_r.rd = r_ff.am[31:0];
        A_MHI:  nxt_r.rd[3:0] = r_ff.am[35:32];
        A_FLG: begin
          nxt_r.rd[F_C]  = r_ff.fc;
          nxt_r.rd[F_V]  = r_ff.fv;
          nxt_r.rd[F_Z]  = r_ff.fz;
          nxt_r.rd[F_N]  = r_ff.fn;
          nxt_r.rd[F_EV] = r_ff.fev;
          nxt_r.rd[F_MV] = r_ff.fmv;
          nxt_r.rd[F_SM] = r_ff.sm;
        end
        A_BANK: begin
          nxt_r.rd[K_EK +: 4] = r_ff.ek;
          nxt_r.rd[K_SK +: 4] = r_ff.sk;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign WB_ACK    = r_ff.ack;
  assign WB_DAT_RD = r_ff.rd;
  assign EXT_BANK  = r_ff.ek;

  //------------------------------------------------------------------
  // checks
  //------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  logic taken;
  assign taken = req && WB_WE && WB_ADR == A_CMD && r_ff.st == ST_IDLE;

  property p_pair_time;
    taken && WB_DAT_WR[15:0] == OP_PAIR |=>
      (r_ff.st == ST_EXEC) [*4] ##1 r_ff.st == ST_IDLE;
  endproperty
  a_pair_time: assert property (p_pair_time)
    else $error("pair load not four cycles");

  property p_pair_val;
    fin && r_ff.op == OP_PAIR |=> r_ff.am == {{4{$past(r_ff.e[15])}},
      $past(r_ff.e), $past(d_w)} && !r_ff.fev && !r_ff.fmv;
  endproperty
  a_pair_val: assert property (p_pair_val)
    else $error("pair load value wrong");

  property p_high_val;
    fin && r_ff.op == OP_HIGH |=> r_ff.am[15:0] == W_ZERO
      && r_ff.am[31:16] == $past(r_ff.e)
      && r_ff.am[35:32] == {4{r_ff.am[31]}} && !r_ff.fmv && !r_ff.fev;
  endproperty
  a_high_val: assert property (p_high_val)
    else $error("high load value wrong");

  property p_bank_b;
    fin && (r_ff.op == OP_EKB || r_ff.op == OP_SKB) |=>
      r_ff.b[7:4] == N_ZERO && $stable({r_ff.fn, r_ff.fz, r_ff.fc});
  endproperty
  a_bank_b: assert property (p_bank_b)
    else $error("bank read wrong");

  property p_sk_time;
    taken && WB_DAT_WR[15:0] == OP_SKB |=>
      r_ff.st == ST_EXEC ##1 r_ff.st == ST_EXEC ##1 r_ff.st == ST_IDLE;
  endproperty
  a_sk_time: assert property (p_sk_time)
    else $error("stack bank read not two cycles");

  property p_rnd;
    fin && r_ff.op == OP_RND && !sat_r |=> r_ff.e == $past(tmp[31:16]);
  endproperty
  a_rnd: assert property (p_rnd)
    else $error("rounded word wrong");

  property p_rnd_sat;
    fin && r_ff.op == OP_RND && sat_r |=> (r_ff.fev | r_ff.fmv)
      && r_ff.e == ($past(r_ff.am[35]) ? SAT_NEG : SAT_POS)
      && r_ff.fn == r_ff.e[15];
  endproperty
  a_rnd_sat: assert property (p_rnd_sat)
    else $error("rounded saturation wrong");

  property p_sat;
    fin && r_ff.op == OP_TRN && sat_t |=>
      r_ff.e == ($past(r_ff.am[35]) ? SAT_NEG : SAT_POS);
  endproperty
  a_sat: assert property (p_sat)
    else $error("saturation value wrong");

  property p_split;
    fin && r_ff.op == OP_SPLIT |=> r_ff.x[15:4] == {12{$past(r_ff.am[35])}}
      && d_w == $past(r_ff.am[15:0]) && $stable(r_ff.fz);
  endproperty
  a_split: assert property (p_split)
    else $error("split wrong");

  property p_test;
    fin && (r_ff.op == OP_TSD || r_ff.op == OP_TSE) |=>
      !r_ff.fv && !r_ff.fc && $stable(r_ff.e) && $stable(d_w);
  endproperty
  a_test: assert property (p_test)
    else $error("word test wrong");

  property p_testa;
    fin && r_ff.op == OP_TSA |=> r_ff.fz == ($past(r_ff.a) == B_ZERO)
      && !r_ff.fc && $stable(r_ff.a);
  endproperty
  a_testa: assert property (p_testa)
    else $error("byte test wrong");

  property p_testb;
    fin && r_ff.op == OP_TSB |=> r_ff.fn == $past(r_ff.b[7])
      && !r_ff.fv && !r_ff.fc && $stable(r_ff.b);
  endproperty
  a_testb: assert property (p_testb)
    else $error("second byte test wrong");
endmodule

// [verif/cto_core_tb.sv]
// self-checking bench for the transfer and test executor
module cto_core_tb import cto_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic          clk             = 1'b0;
  logic          rst             = 1'b1;
  logic          cyc             = 1'b0;
  logic          stb             = 1'b0;
  logic          we              = 1'b0;
  logic [AW-1:0] adr             = '0;
  logic [3:0]    sel             = 4'hF;
  logic [DW-1:0] dwr             = '0;
  logic [DW-1:0] drd;
  logic          ack;
  logic [3:0]    bank;
  logic [DW-1:0] rv;
  int            num_errors      = 0;
  int            samples_checked = 0;
  logic [15:0]   t_op [4]        = '{OP_TSA, OP_TSB, OP_TSD, OP_TSE};
  logic [DW-1:0] t_fl [4]        = '{32'h0000_0038, 32'h0000_0034,
                                     32'h0000_0038, 32'h0000_0030};

  always #5 clk = ~clk;

  cto_core uut (
    .CLK       (clk),
    .RST       (rst),
    .WB_CYC    (cyc),
    .WB_STB    (stb),
    .WB_WE     (we),
    .WB_ADR    (adr),
    .WB_SEL    (sel),
    .WB_DAT_WR (dwr),
    .WB_DAT_RD (drd),
    .WB_ACK    (ack),
    .EXT_BANK  (bank)
  );

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("checked %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [DW-1:0] exp,
                     input logic [DW-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // called just after a rising edge; returns just after one
  task automatic bus(input logic w, input logic [AW-1:0] a,
                     input logic [DW-1:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dwr <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rv = drd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      num_errors++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input string what, input logic [AW-1:0] a,
                    input logic [DW-1:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(what, exp, rv);
  endtask

  // a hung executor would leave busy up forever
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, A_STAT, 32'h0000_0000);
      n++;
    end while (rv[S_BUSY] !== 1'b0 && n < 10);
    if (n >= 10) begin
      num_errors++;
      finish_test();
    end
  endtask

  // busy still up at the first read only for the 4 and 6 cycle ops
  task automatic op(input logic [15:0] code, input logic busy);
    wr(A_CMD, {16'h0000, code});
    rd("busy", A_STAT, busy ? 32'h0000_0001 : 32'h0000_0000);
    wait_idle();
  endtask

  task automatic mac(input logic [35:0] v);
    wr(A_MLO, v[31:0]);
    wr(A_MHI, {28'h000_0000, v[35:32]});
  endtask

  task automatic tdone(input string name);
    $display("test done: %s", name);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("reset d", A_D, 32'h0000_0000);
    rd("reset flags", A_FLG, 32'h0000_0000);
    wr(6'h24, 32'hFFFF_FFFF);
    rd("unmapped", 6'h24, 32'h0000_0000);
    tdone("reset and map");
    wr(A_D, 32'h0000_1234);
    wr(A_E, 32'h0000_8001);
    wr(A_FLG, 32'h0000_003F);
    wr(A_CMD, {16'h0000, OP_PAIR});
    wr(A_E, 32'h0000_AAAA);
    wait_idle();
    rd("pair lo", A_MLO, 32'h8001_1234);
    rd("pair hi", A_MHI, 32'h0000_000F);
    rd("pair flags", A_FLG, 32'h0000_000F);
    rd("busy write", A_E, 32'h0000_8001);
    wr(A_E, 32'h0000_7FFF);
    wr(A_FLG, 32'h0000_0030);
    op(OP_HIGH, 1'b1);
    rd("high lo", A_MLO, 32'h7FFF_0000);
    rd("high hi", A_MHI, 32'h0000_0000);
    rd("high flags", A_FLG, 32'h0000_0000);
    tdone("mac loads");
    mac(36'h9_1234_5678);
    wr(A_FLG, 32'h0000_000F);
    op(OP_SPLIT, 1'b1);
    rd("split x", A_X, 32'h0000_FFF9);
    rd("split e", A_E, 32'h0000_1234);
    rd("split d", A_D, 32'h0000_5678);
    rd("split flags", A_FLG, 32'h0000_000F);
    sel <= 4'h2;
    wr(A_X, 32'h0000_AB00);
    sel <= 4'hF;
    rd("x byte lane", A_X, 32'h0000_ABF9);
    tdone("split");
    wr(A_BANK, 32'h0000_005A);
    wr(A_D, 32'h0000_FFFF);
    chk("ext bank", 32'h0000_000A, {28'h000_0000, bank});
    op(OP_EKB, 1'b0);
    rd("ekb d", A_D, 32'h0000_FF0A);
    op(OP_SKB, 1'b0);
    rd("skb d", A_D, 32'h0000_FF05);
    rd("bank flags", A_FLG, 32'h0000_000F);
    tdone("bank reads");
    mac(36'h0_1234_8000);
    wr(A_FLG, 32'h0000_0000);
    op(OP_RND, 1'b1);
    rd("round e", A_E, 32'h0000_1235);
    rd("round flags", A_FLG, 32'h0000_0000);
    mac(36'h0_7FFF_8000);
    wr(A_FLG, 32'h0000_0040);
    op(OP_RND, 1'b1);
    rd("sat pos e", A_E, 32'h0000_7FFF);
    rd("sat pos flags", A_FLG, 32'h0000_0050);
    mac(36'h8_0000_0000);
    wr(A_FLG, 32'h0000_0040);
    op(OP_RND, 1'b1);
    rd("sat neg e", A_E, 32'h0000_8000);
    rd("sat neg flags", A_FLG, 32'h0000_0058);
    mac(36'h7_FFFF_8000);
    wr(A_FLG, 32'h0000_0000);
    op(OP_RND, 1'b1);
    rd("round mv e", A_E, 32'h0000_0000);
    rd("round mv flags", A_FLG, 32'h0000_0034);
    tdone("rounded");
    mac(36'h0_1234_FFFF);
    wr(A_FLG, 32'h0000_0000);
    op(OP_TRN, 1'b0);
    rd("trunc e", A_E, 32'h0000_1234);
    wr(A_FLG, 32'h0000_0060);
    op(OP_TRN, 1'b0);
    rd("trunc sat e", A_E, 32'h0000_7FFF);
    rd("trunc sat flags", A_FLG, 32'h0000_0060);
    mac(36'h0_0000_1234);
    wr(A_FLG, 32'h0000_0000);
    op(OP_TRN, 1'b0);
    rd("trunc zero", A_FLG, 32'h0000_0004);
    tdone("truncated");
    wr(A_D, 32'h0000_8000);
    wr(A_E, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      wr(A_FLG, 32'h0000_0033);
      op(t_op[i], 1'b0);
      rd("test flags", A_FLG, t_fl[i]);
    end
    rd("test d kept", A_D, 32'h0000_8000);
    rd("test e kept", A_E, 32'h0000_0001);
    tdone("tests");
    wr(A_CMD, 32'h0000_1234);
    repeat (4) @(posedge clk);
    rd("bad opcode", A_STAT, 32'h0000_0002);
    op(OP_TSE, 1'b0);
    rd("bad cleared", A_STAT, 32'h0000_0000);
    rd("last op", A_CMD, {16'h0000, OP_TSE});
    tdone("bad opcode");
    finish_test();
  end
endmodule
